// File: src/mrss_pkg.sv
// constants shared by the reset source sequencer
package mrss_pkg;
	localparam int SYS_CLK_MHZ = 250;
	// hold and stabilisation times in ns
	localparam int POR_HOLD_NS = 10000;
	localparam int LVD_STAB_NS = 2000;
	localparam int WDT_HOLD_NS = 500;
	localparam int SW_HOLD_NS = 1000;
	localparam int PAR_HOLD_NS = 1000;
	// least times, rounded up to whole cycles
	localparam int POR_HOLD_CYC = (POR_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int LVD_STAB_CYC = (LVD_STAB_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int WDT_HOLD_CYC = (WDT_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int SW_HOLD_CYC = (SW_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int PAR_HOLD_CYC = (PAR_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int HOLD_W = 12;
	// timed reset sources
	localparam int SRC_POR = 0;
	localparam int SRC_LVD0 = 1;
	localparam int SRC_LVD1 = 2;
	localparam int SRC_WDT = 3;
	localparam int SRC_SW = 4;
	localparam int SRC_PAR = 5;
	localparam int NSRC = 6;
	localparam int HOLD_CYC [NSRC] = '{POR_HOLD_CYC, LVD_STAB_CYC, LVD_STAB_CYC,
		WDT_HOLD_CYC, SW_HOLD_CYC, PAR_HOLD_CYC};
	// register offsets
	localparam logic [7:0] OFS_POWER_ON_STATUS = 8'h00;
	localparam logic [7:0] OFS_CAUSE_FLAG = 8'h04;
	localparam logic [7:0] OFS_CAUSE_STATUS_ONE = 8'h08;
	localparam logic [7:0] OFS_SUPPLY_MON1_CTRL = 8'h0C;
	localparam logic [7:0] OFS_WDT_CFG = 8'h10;
	// cause_flag_reg bits
	localparam int CF_PIN = 0;
	localparam int CF_LVD0 = 1;
	localparam int CF_LVD1 = 2;
	localparam int CF_PAR = 3;
	localparam int CF_SW = 4;
	localparam int CF_W = 5;
	// option_select_word_one bits
	localparam int OPT_PINSEL = 0;
	localparam int OPT_M0_EN = 1;
	localparam int OPT_M0_RST = 2;
	localparam int OPT_M0_LVL = 3;
	localparam int OPT_W = 6;
	// supply_monitor1_ctrl bits
	localparam int M1_EN = 0;
	localparam int M1_RST = 1;
	localparam int M1_LVL = 4;
	localparam int M0_LEVELS = 6;
	localparam int M1_LEVELS = 18;
	// reset values
	localparam logic WDT_RST_MODE_RST = 1'b1;
endpackage

// File: src/mrss_hold_if.sv
// trigger and hold pair between the sequencer and one hold timer
`timescale 1ns/1ps
interface mrss_hold_if;
	logic trig;
	logic hold;
	modport src(output trig, input hold);
	modport tmr(input trig, output hold);
endinterface

// File: src/mrss_hold_timer.sv
// hold timer: keeps a reset asserted for a fixed time after its trigger ends
`timescale 1ns/1ps
module mrss_hold_timer import mrss_pkg::*; #(
	parameter int CW = HOLD_W,
	parameter int LOAD = 1,
	parameter int RST_CNT = 0
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	mrss_hold_if.tmr hold_port
);
	initial begin
		if (LOAD < 1 || LOAD >= (1 << CW) || RST_CNT < 0 || RST_CNT >= (1 << CW)) begin
			$error("hold count does not fit the counter");
		end
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
	} mrss_tmr_state_t;

	mrss_tmr_state_t st_reg;
	mrss_tmr_state_t st_next;

	always_comb begin
		st_next = st_reg;
		// reload while the trigger stands, so the time counts from its end
		if (hold_port.trig) begin
			st_next.cnt = CW'(LOAD);
		end else if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - CW'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_reg.cnt <= CW'(RST_CNT);
		end else begin
			st_reg <= st_next;
		end
	end

	assign hold_port.hold = hold_port.trig | (st_reg.cnt != '0);
endmodule

// File: src/mrss_sequencer.sv
// reset source sequencer: merges reset sources and records their causes
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module mrss_sequencer import mrss_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic external_init_pin_n_i,
	input wire logic supply_below_por_i,
	input wire logic supply_below_mon0_i,
	input wire logic supply_below_mon1_i,
	input wire logic [OPT_W-1:0] option_select_word_one_i,
	input wire logic wdt_underflow_i,
	input wire logic wdt_refresh_err_i,
	input wire logic parity_err_i,
	input wire logic system_restart_request_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic sys_rst_o,
	output logic nmi_o,
	output logic mon0_irq_o,
	output logic mon1_irq_o,
	output logic shared_general_port_pin_o,
	output logic mon0_enable_o,
	output logic mon1_enable_o,
	output logic [2:0] monitor0_threshold_o,
	output logic [4:0] monitor1_threshold_o
);
	typedef struct packed {
		logic [2:0] pin_s;
		logic [2:0] por_s;
		logic [2:0] m0_s;
		logic [2:0] m1_s;
		logic pin_f;
		logic por_f;
		logic m0_f;
		logic m1_f;
		logic cold_start_flag;
		logic [CF_W-1:0] cause;
		logic watchdog_cause_flag;
		logic wdt_rst_mode;
		logic m1_en;
		logic m1_rst;
		logic [4:0] m1_lvl;
		logic [2:0] m0_lvl;
		logic normal;
		logic sys_rst;
		logic nmi;
		logic irq0;
		logic irq1;
		logic [31:0] rdata;
	} mrss_state_t;

	mrss_state_t st_reg;
	mrss_state_t st_next;
	logic [NSRC-1:0] trig_vec;
	logic [NSRC-1:0] hold_vec;
	logic pin_rst;
	logic por_trig;

	mrss_hold_if hold_bus [NSRC] ();

	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_src
			// power-on timer starts loaded so supply ramp-up is covered
			mrss_hold_timer #(
				.CW(HOLD_W),
				.LOAD(HOLD_CYC[g]),
				.RST_CNT(g == SRC_POR ? POR_HOLD_CYC : 0)
			) u_tmr (
				.sys_clk_i(sys_clk_i),
				.srst_i(srst_i),
				.hold_port(hold_bus[g])
			);
			assign hold_bus[g].trig = trig_vec[g];
			assign hold_vec[g] = hold_bus[g].hold;
		end
	endgenerate

	// pin reset; a port-mode pin still resets before normal run
	assign pin_rst = !st_reg.pin_f &&
		(option_select_word_one_i[OPT_PINSEL] || !st_reg.normal);
	// the pin sense comes from the filtered level, never from raw stages
	assign por_trig = st_reg.por_f && st_reg.pin_f;

	always_comb begin
		trig_vec = '0;
		trig_vec[SRC_POR] = por_trig;
		trig_vec[SRC_LVD0] = st_reg.m0_f && option_select_word_one_i[OPT_M0_EN] &&
			option_select_word_one_i[OPT_M0_RST];
		trig_vec[SRC_LVD1] = st_reg.m1_f && st_reg.m1_en && st_reg.m1_rst;
		trig_vec[SRC_WDT] = (wdt_underflow_i && st_reg.wdt_rst_mode) ||
			wdt_refresh_err_i;
		trig_vec[SRC_SW] = system_restart_request_i;
		trig_vec[SRC_PAR] = parity_err_i;
	end

	always_comb begin
		st_next = st_reg;
		// three-stage sampling; a change counts once stages two and three agree
		st_next.pin_s = {st_reg.pin_s[1:0], external_init_pin_n_i};
		st_next.por_s = {st_reg.por_s[1:0], supply_below_por_i};
		st_next.m0_s = {st_reg.m0_s[1:0], supply_below_mon0_i};
		st_next.m1_s = {st_reg.m1_s[1:0], supply_below_mon1_i};
		if (st_reg.pin_s[1] == st_reg.pin_s[2]) begin
			st_next.pin_f = st_reg.pin_s[2];
		end
		if (st_reg.por_s[1] == st_reg.por_s[2]) begin
			st_next.por_f = st_reg.por_s[2];
		end
		if (st_reg.m0_s[1] == st_reg.m0_s[2]) begin
			st_next.m0_f = st_reg.m0_s[2];
		end
		if (st_reg.m1_s[1] == st_reg.m1_s[2]) begin
			st_next.m1_f = st_reg.m1_s[2];
		end
		// any hold still running keeps the whole device in reset
		st_next.sys_rst = (|hold_vec) || pin_rst;
		if (!st_reg.sys_rst) begin
			st_next.normal = 1'b1;
		end
		// clamp out-of-range level codes to the highest legal one
		if (option_select_word_one_i[OPT_M0_LVL +: 3] >= 3'(M0_LEVELS)) begin
			st_next.m0_lvl = 3'(M0_LEVELS - 1);
		end else begin
			st_next.m0_lvl = option_select_word_one_i[OPT_M0_LVL +: 3];
		end
		st_next.nmi = wdt_underflow_i && !st_reg.wdt_rst_mode;
		st_next.irq0 = st_next.m0_f && !st_reg.m0_f && option_select_word_one_i[OPT_M0_EN] &&
			!option_select_word_one_i[OPT_M0_RST];
		st_next.irq1 = st_next.m1_f && !st_reg.m1_f && st_reg.m1_en && !st_reg.m1_rst;
		// software writes; a clear of a cause flag loses to a new event below
		if (wr_i) begin
			case (addr_i)
				OFS_POWER_ON_STATUS: begin
					if (wdata_i[0]) begin
						st_next.cold_start_flag = 1'b1;
					end
				end
				OFS_CAUSE_FLAG: begin
					st_next.cause = st_reg.cause & ~wdata_i[CF_W-1:0];
				end
				OFS_CAUSE_STATUS_ONE: begin
					if (wdata_i[0]) begin
						st_next.watchdog_cause_flag = 1'b0;
					end
				end
				OFS_SUPPLY_MON1_CTRL: begin
					st_next.m1_en = wdata_i[M1_EN];
					st_next.m1_rst = wdata_i[M1_RST];
					// an illegal level code leaves the old level in place
					if (wdata_i[M1_LVL +: 5] < 5'(M1_LEVELS)) begin
						st_next.m1_lvl = wdata_i[M1_LVL +: 5];
					end
				end
				OFS_WDT_CFG: begin
					st_next.wdt_rst_mode = wdata_i[0];
				end
				default: begin
				end
			endcase
		end
		if (pin_rst && option_select_word_one_i[OPT_PINSEL]) begin
			st_next.cause[CF_PIN] = 1'b1;
		end
		if (trig_vec[SRC_LVD0]) begin
			st_next.cause[CF_LVD0] = 1'b1;
		end
		if (trig_vec[SRC_LVD1]) begin
			st_next.cause[CF_LVD1] = 1'b1;
		end
		if (trig_vec[SRC_PAR]) begin
			st_next.cause[CF_PAR] = 1'b1;
		end
		if (trig_vec[SRC_SW]) begin
			st_next.cause[CF_SW] = 1'b1;
		end
		if (trig_vec[SRC_WDT]) begin
			st_next.watchdog_cause_flag = 1'b1;
		end
		// power-on wipes history and disables monitor 1, beating any write
		if (por_trig) begin
			st_next.cold_start_flag = 1'b0;
			st_next.cause = '0;
			st_next.watchdog_cause_flag = 1'b0;
			st_next.m1_en = 1'b0;
			st_next.m1_rst = 1'b0;
			st_next.m1_lvl = '0;
			st_next.normal = 1'b0;
		end
		st_next.rdata = '0;
		if (rd_i) begin
			case (addr_i)
				OFS_POWER_ON_STATUS: st_next.rdata[0] = st_reg.cold_start_flag;
				OFS_CAUSE_FLAG: st_next.rdata[CF_W-1:0] = st_reg.cause;
				OFS_CAUSE_STATUS_ONE: st_next.rdata[0] = st_reg.watchdog_cause_flag;
				OFS_SUPPLY_MON1_CTRL: begin
					st_next.rdata[M1_EN] = st_reg.m1_en;
					st_next.rdata[M1_RST] = st_reg.m1_rst;
					st_next.rdata[M1_LVL +: 5] = st_reg.m1_lvl;
				end
				OFS_WDT_CFG: st_next.rdata[0] = st_reg.wdt_rst_mode;
				default: st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_reg <= '0;
			st_reg.pin_s <= 3'h7;
			st_reg.pin_f <= 1'b1;
			st_reg.sys_rst <= 1'b1;
			st_reg.wdt_rst_mode <= WDT_RST_MODE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;
	assign sys_rst_o = st_reg.sys_rst;
	assign nmi_o = st_reg.nmi;
	assign mon0_irq_o = st_reg.irq0;
	assign mon1_irq_o = st_reg.irq1;
	assign shared_general_port_pin_o = st_reg.pin_f;
	assign mon0_enable_o = option_select_word_one_i[OPT_M0_EN];
	assign mon1_enable_o = st_reg.m1_en;
	assign monitor0_threshold_o = st_reg.m0_lvl;
	assign monitor1_threshold_o = st_reg.m1_lvl;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	sequence sw_req_s;
		system_restart_request_i && !por_trig;
	endsequence
	sequence held_eight_s;
		sys_rst_o [*8];
	endsequence

	pin_low_reset_a: assert property (pin_rst |=> sys_rst_o)
		else $error("pin low did not hold reset");
	por_clear_a: assert property (por_trig |=> !st_reg.cold_start_flag)
		else $error("power-on did not clear cold-start flag");
	cold_zero_write_a: assert property (wr_i && addr_i == OFS_POWER_ON_STATUS && !wdata_i[0]
		&& st_reg.cold_start_flag && !por_trig |=> st_reg.cold_start_flag)
		else $error("zero write cleared cold-start flag");
	por_hold_a: assert property ($fell(por_trig) |-> ##1 held_eight_s)
		else $error("power-on reset released too early");
	wdt_mode_a: assert property (wdt_underflow_i && !wdt_refresh_err_i |=>
		(st_reg.watchdog_cause_flag && sys_rst_o) || nmi_o)
		else $error("watchdog underflow gave neither reset nor nmi");
	refresh_rst_a: assert property (wdt_refresh_err_i |=> ##1 sys_rst_o)
		else $error("refresh violation gave no reset");
	sw_hold_a: assert property (sw_req_s |=> ##1 held_eight_s)
		else $error("software reset not held");
	parity_rst_a: assert property (parity_err_i && !por_trig |=>
		st_reg.cause[CF_PAR] ##1 sys_rst_o)
		else $error("parity error gave no reset");
	mon1_off_a: assert property (por_trig |=> !mon1_enable_o)
		else $error("monitor 1 enabled after power-on");
	brown_flag_a: assert property (trig_vec[SRC_LVD1] && !por_trig |=>
		st_reg.cause[CF_LVD1])
		else $error("monitor reset without cause flag");

	// per-source checks; a power-on in the same cycle wipes flags, so it is excluded
	wdt_flag_a: assert property (wdt_refresh_err_i && !por_trig |=>
		st_reg.watchdog_cause_flag)
		else $error("refresh violation without watchdog flag");
	sw_flag_a: assert property (sw_req_s |=>
		st_reg.cause[CF_SW])
		else $error("software reset without cause flag");
	mon0_flag_a: assert property (trig_vec[SRC_LVD0] && !por_trig |=>
		st_reg.cause[CF_LVD0])
		else $error("monitor 0 reset without cause flag");
	lvd0_rst_a: assert property (trig_vec[SRC_LVD0] |=>
		sys_rst_o)
		else $error("monitor 0 gave no reset");
	lvd1_rst_a: assert property (trig_vec[SRC_LVD1] |=>
		sys_rst_o)
		else $error("monitor 1 gave no reset");
	por_rst_a: assert property (por_trig |=>
		sys_rst_o)
		else $error("power-on gave no reset");
	any_src_a: assert property ((|hold_vec) |=>
		sys_rst_o)
		else $error("reset released while a hold runs");
	all_done_a: assert property (!(|hold_vec) && !pin_rst |=>
		!sys_rst_o)
		else $error("reset kept with no source active");
	mon1_level_a: assert property (1'b1 |->
		monitor1_threshold_o < 5'(M1_LEVELS))
		else $error("monitor 1 level out of range");
	mon0_level_a: assert property (1'b1 |->
		monitor0_threshold_o < 3'(M0_LEVELS))
		else $error("monitor 0 level out of range");
	nmi_mode_a: assert property (wdt_underflow_i && !st_reg.wdt_rst_mode |=>
		nmi_o)
		else $error("underflow in nmi mode gave no nmi");
	cold_keep_a: assert property (!por_trig && !(wr_i && addr_i == OFS_POWER_ON_STATUS) |=>
		$stable(st_reg.cold_start_flag))
		else $error("cold-start flag changed without cause");
	// hold checks only look eight cycles ahead; the full length is a bench job
	par_hold_a: assert property (parity_err_i && !por_trig |=>
		##1 held_eight_s)
		else $error("parity reset not held");
	wdt_hold_a: assert property (wdt_refresh_err_i |=>
		##1 held_eight_s)
		else $error("watchdog reset not held");
	lvd_stab_a: assert property ($fell(trig_vec[SRC_LVD1]) |->
		##1 held_eight_s)
		else $error("monitor reset released without stabilisation");
	pin_port_a: assert property (!st_reg.pin_f && st_reg.normal &&
		!option_select_word_one_i[OPT_PINSEL] |-> !pin_rst)
		else $error("port-mode pin reset during normal run");
endmodule

// File: tb/mrss_board_model.sv
// board-side model: reset pin with pull-up and supply detectors
`timescale 1ns/1ps
module mrss_board_model #(
	parameter int MIN_PW = 8
) (
	input wire logic sys_clk_i,
	input wire logic [3:0] ev_i,
	input wire logic port_mode_i,
	input wire logic in_reset_i,
	output logic pin_n_o,
	output logic [2:0] below_o
);
	// ev 0 pin low, 1 supply under power-on level, 2 and 3 under monitor levels
	int cnt [4] = '{0, 0, 0, 0};
	always @(posedge sys_clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (ev_i[i] && !(i == 0 && port_mode_i && in_reset_i)) begin
				cnt[i] <= MIN_PW;
			end else if (cnt[i] > 0) begin
				cnt[i] <= cnt[i] - 1;
			end
		end
	end
	// released pin goes to its pull-up level
	assign pin_n_o = (cnt[0] == 0);
	// a supply under the power-on level is under both monitor levels too
	assign below_o = (cnt[1] != 0) ? 3'h7 : {cnt[3] != 0, cnt[2] != 0, 1'b0};
endmodule

// File: tb/tb_top.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
module tb_top;
	import mrss_pkg::*;
	localparam int PW = 8;
	logic sys_clk_i, srst_i, wr, rd, rst, nmi, irq0, irq1, pin_n, port_o, en0, en1;
	logic [7:0] stim, addr;
	logic [OPT_W-1:0] opt;
	logic [2:0] below, th0;
	logic [4:0] th1;
	logic [31:0] wdata, rdata;
	int mismatches, tests_run;
	mrss_sequencer dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.external_init_pin_n_i(pin_n), .supply_below_por_i(below[0]),
		.supply_below_mon0_i(below[1]), .supply_below_mon1_i(below[2]),
		.option_select_word_one_i(opt), .wdt_underflow_i(stim[0]),
		.wdt_refresh_err_i(stim[1]), .parity_err_i(stim[2]),
		.system_restart_request_i(stim[3]), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .sys_rst_o(rst), .nmi_o(nmi), .mon0_irq_o(irq0),
		.mon1_irq_o(irq1), .shared_general_port_pin_o(port_o), .mon0_enable_o(en0),
		.mon1_enable_o(en1), .monitor0_threshold_o(th0), .monitor1_threshold_o(th1));
	mrss_board_model #(.MIN_PW(PW)) board (.sys_clk_i(sys_clk_i), .ev_i(stim[7:4]),
		.port_mode_i(!opt[OPT_PINSEL]), .in_reset_i(rst), .pin_n_o(pin_n), .below_o(below));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = !sys_clk_i;
	end
	task automatic final_report();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		#1 chk(rdata, exp);
		@(posedge sys_clk_i);
	endtask
	task automatic pulse(input int i);
		stim[i] <= 1'b1;
		@(posedge sys_clk_i);
		stim[i] <= 1'b0;
	endtask
	// waits for reset to rise, then counts the cycles it stays high
	task automatic hold_len(input int lo, input int hi);
		int n;
		n = 0;
		#1;
		while (rst !== 1'b1 && n < 20) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		n = 0;
		while (rst === 1'b1 && n < 6000) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		tests_run++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("[ERR] %0t reset held %0d cycles", $time, n);
		end
		if (n >= 6000) final_report();
		@(posedge sys_clk_i);
	endtask
	task automatic hit(input int i, input int lo, input int hi, input logic [7:0] a,
		input logic [31:0] v);
		pulse(i);
		hold_len(lo, hi);
		rd_reg(a, v);
		wr_reg(a, v);
	endtask
	// counts one-cycle pulses over 20 cycles; any reset spoils the count
	task automatic see_pulse(input int s, input int w);
		int n;
		n = 0;
		stim[s] <= 1'b1;
		repeat (20) begin
			@(posedge sys_clk_i);
			stim[s] <= 1'b0;
			#1 n += (w == 0) ? nmi : (w == 1) ? irq0 : irq1;
			if (rst !== 1'b0) n += 100;
		end
		chk(n, 1);
		@(posedge sys_clk_i);
	endtask
	initial begin
		mismatches = 0;
		tests_run = 0;
		srst_i = 1'b1;
		stim = 8'h00;
		opt = 6'h01;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		hold_len(POR_HOLD_CYC, POR_HOLD_CYC + 4);
		chk({en0, en1}, 2'h0);
		rd_reg(OFS_POWER_ON_STATUS, 32'h0);
		wr_reg(OFS_POWER_ON_STATUS, 32'h1);
		wr_reg(OFS_POWER_ON_STATUS, 32'h0);
		rd_reg(OFS_POWER_ON_STATUS, 32'h1);
		rd_reg(8'h40, 32'h0);
		hit(3, SW_HOLD_CYC, SW_HOLD_CYC + 3, OFS_CAUSE_FLAG, 32'h10);
		rd_reg(OFS_POWER_ON_STATUS, 32'h1);
		hit(2, PAR_HOLD_CYC, PAR_HOLD_CYC + 3, OFS_CAUSE_FLAG, 32'h08);
		hit(0, WDT_HOLD_CYC, WDT_HOLD_CYC + 3, OFS_CAUSE_STATUS_ONE, 32'h1);
		hit(1, WDT_HOLD_CYC, WDT_HOLD_CYC + 3, OFS_CAUSE_STATUS_ONE, 32'h1);
		opt <= 6'h3F;
		repeat (2) @(posedge sys_clk_i);
		#1 chk({en0, th0}, 4'hD);
		@(posedge sys_clk_i);
		hit(6, LVD_STAB_CYC + 6, LVD_STAB_CYC + 12, OFS_CAUSE_FLAG, 32'h02);
		hit(4, PW - 2, PW + 3, OFS_CAUSE_FLAG, 32'h01);
		wr_reg(OFS_SUPPLY_MON1_CTRL, 32'h113);
		wr_reg(OFS_SUPPLY_MON1_CTRL, 32'h123);
		rd_reg(OFS_SUPPLY_MON1_CTRL, 32'h113);
		chk({en1, th1}, 6'h31);
		hit(7, LVD_STAB_CYC + 6, LVD_STAB_CYC + 12, OFS_CAUSE_FLAG, 32'h04);
		wr_reg(OFS_WDT_CFG, 32'h0);
		see_pulse(0, 0);
		rd_reg(OFS_CAUSE_STATUS_ONE, 32'h0);
		opt <= 6'h3B;
		wr_reg(OFS_SUPPLY_MON1_CTRL, 32'h111);
		see_pulse(6, 1);
		see_pulse(7, 2);
		// software hold still running when parity arrives
		pulse(3);
		repeat (100) @(posedge sys_clk_i);
		pulse(2);
		hold_len(PAR_HOLD_CYC, PAR_HOLD_CYC + 3);
		rd_reg(OFS_CAUSE_FLAG, 32'h18);
		opt <= 6'h00;
		pulse(4);
		repeat (6) @(posedge sys_clk_i);
		#1 chk({port_o, rst}, 2'h0);
		repeat (10) @(posedge sys_clk_i);
		hit(5, POR_HOLD_CYC + 6, POR_HOLD_CYC + 12, OFS_POWER_ON_STATUS, 32'h0);
		rd_reg(OFS_SUPPLY_MON1_CTRL, 32'h0);
		final_report();
	end
endmodule
